// *** src/ubt_pkg.sv ***
package ubt_pkg;
   localparam logic [3:0] ADDR_BUF      = 4'h0;
   localparam logic [3:0] ADDR_CTRL     = 4'h1;
   localparam logic [3:0] ADDR_POWER    = 4'h2;
   localparam logic [3:0] ADDR_CONFIG   = 4'h3;
   localparam logic [3:0] ADDR_TLOW     = 4'h4;
   localparam logic [3:0] ADDR_THIGH    = 4'h5;
   localparam logic [3:0] ADDR_TCTRL    = 4'h6;
   localparam logic [3:0] ADDR_TCLKSEL  = 4'h7;
   localparam logic [3:0] ADDR_SRCSEL   = 4'h8;
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_MP      = 5;
   localparam int CTRL_REN     = 4;
   localparam int CTRL_TB8     = 3;
   localparam int CTRL_RB8     = 2;
   localparam int CTRL_TI      = 1;
   localparam int CTRL_RI      = 0;
   localparam int POWER_DBL    = 7;
   localparam int CONFIG_DBL   = 0;
   localparam int SRC_T2       = 0;
   localparam int TCTRL_SEL_HI = 7;
   localparam int TCTRL_SEL_LO = 5;
   localparam logic [7:0] TCTRL_MASK   = 8'hEB;
   localparam logic [7:0] TCLKSEL_MASK = 8'h07;
   localparam logic [7:0] REG_RST      = 8'h00;
   localparam logic [2:0] SEL_GT1 = 3'h0;
   localparam logic [2:0] SEL_T0  = 3'h1;
   localparam logic [2:0] SEL_T1  = 3'h2;
   localparam logic [2:0] SEL_T2  = 3'h4;
   localparam logic [1:0] MODE_SHIFT  = 2'h0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h1;
   localparam logic [1:0] MODE_FIXED9 = 2'h2;
   localparam logic [1:0] MODE_VAR9   = 2'h3;
   localparam logic [1:0] MC_LAST     = 2'h2;
   localparam logic [5:0] M0_LEAD_MC  = 6'h04;
   localparam logic [5:0] M0_END_MC   = 6'h24;
   localparam logic [3:0] SMP_A       = 4'h6;
   localparam logic [3:0] SMP_B       = 4'h7;
   localparam logic [3:0] SMP_C       = 4'h8;
   localparam logic [3:0] TICK_LAST   = 4'hF;
   localparam logic [3:0] FRAME8      = 4'hA;
   localparam logic [3:0] FRAME9      = 4'hB;
   localparam logic [3:0] RX_LAST_IDX = 4'h9;
   localparam logic [1:0] FIX64_LAST  = 2'h3;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_SHIFT = 3'b010,
      TX_ASYNC = 3'b100
   } ubt_tx_state_e;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b01,
      RX_ASYNC = 2'b10
   } ubt_rx_state_e;
endpackage

// *** src/ubt_baud_timer.sv ***
`timescale 1ns/1ps
module ubt_baud_timer (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       clkCount,
   input  wire logic       mcTick,
   input  wire logic       wrLow,
   input  wire logic       wrHigh,
   input  wire logic [7:0] wrData,
   output logic      [7:0] count_r,
   output logic      [7:0] reload_r,
   output logic            ovf_r
);
   logic step;

   // no prescaler and no interrupt path, overflow feeds timerOvf, and the uart for timer 0 only
   assign step = run && (clkCount || mcTick);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= ubt_pkg::REG_RST;
         ovf_r   <= 1'b0;
      end else begin
         ovf_r <= step && (count_r == 8'hFF);
         if (wrLow) begin
            count_r <= wrData;
         end else if (step) begin
            count_r <= (count_r == 8'hFF) ? reload_r : count_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_r <= ubt_pkg::REG_RST;
      end else if (wrHigh) begin
         reload_r <= wrData;
      end
   end
endmodule

// *** src/ubt_rx_sampler.sv ***
`timescale 1ns/1ps
module ubt_rx_sampler (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic tick16,
   input  wire logic rxd,
   output logic      bitStb_r,
   output logic      bitVal_r
);
   logic [3:0] cnt_r;
   logic       smpA_r;
   logic       smpB_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r    <= 4'h0;
         smpA_r   <= 1'b0;
         smpB_r   <= 1'b0;
         bitStb_r <= 1'b0;
         bitVal_r <= 1'b1;
      end else begin
         bitStb_r <= 1'b0;
         if (start) begin
            cnt_r <= 4'h0;
         end else if (tick16) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == ubt_pkg::SMP_A) begin
               smpA_r <= rxd;
            end
            if (cnt_r == ubt_pkg::SMP_B) begin
               smpB_r <= rxd;
            end
            if (cnt_r == ubt_pkg::SMP_C) begin
               // majority of the three central samples rejects a single glitch
               bitVal_r <= (smpA_r & smpB_r) | (smpA_r & rxd) | (smpB_r & rxd);
               bitStb_r <= 1'b1;
            end
         end
      end
   end
endmodule

// *** src/ubt_uart_with_baud_timers.sv ***
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ubt_uart_with_baud_timers (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStb,
   input  wire logic       rdStb,
   output logic      [7:0] rdData,
   input  wire logic       rxdIn,
   output logic            rxdOut,
   output logic            rxdOe,
   output logic            txd,
   input  wire logic       genTimerOneOvf,
   input  wire logic       genTimerTwoOvf,
   output logic      [2:0] timerOvf
);
   logic [7:0] ctrl_r;
   logic [7:0] rxBuf_r;
   logic       rateDbl_r;
   logic       extraDbl_r;
   logic       t2Sel_r;
   logic [7:0] tctrl_r;
   logic [2:0] clkSel_r;
   logic [7:0] rdData_r;
   logic [1:0] mcPhase_r;
   logic       mcTick;
   logic [1:0] mode;
   logic [2:0] timerRun;
   logic [2:0] timerWrLow;
   logic [2:0] timerWrHigh;
   logic [7:0] timerCount [3];
   logic [7:0] timerReload [3];
   logic [2:0] sel;
   logic       wrBuf;
   logic       wrCtrl;
   logic       tiSet;
   logic       riSet;
   logic       rb8Load;
   logic       rb8Val;

   assign mode  = ctrl_r[ubt_pkg::CTRL_MODE_HI:ubt_pkg::CTRL_MODE_LO];
   assign sel   = tctrl_r[ubt_pkg::TCTRL_SEL_HI:ubt_pkg::TCTRL_SEL_LO];
   assign wrBuf = wrStb && (addr == ubt_pkg::ADDR_BUF);
   assign wrCtrl = wrStb && (addr == ubt_pkg::ADDR_CTRL);
   assign timerRun = {tctrl_r[3], tctrl_r[1], tctrl_r[0]};
   assign mcTick = (mcPhase_r == ubt_pkg::MC_LAST);

   // machine cycle is three clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mcPhase_r <= 2'h0;
      end else begin
         mcPhase_r <= mcTick ? 2'h0 : mcPhase_r + 2'h1;
      end
   end

   // three dedicated timers, only timer 0 can feed the uart; selector codes are one-hot above 000
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gTimer
         localparam logic [2:0] SEL_CODE = 3'h1 << g;
         assign timerWrLow[g]  = wrStb && (addr == ubt_pkg::ADDR_TLOW) && (sel == SEL_CODE);
         assign timerWrHigh[g] = wrStb && (addr == ubt_pkg::ADDR_THIGH) && (sel == SEL_CODE);
         ubt_baud_timer uTimer (
            .clk      (clk),
            .rst_n    (rst_n),
            .run      (timerRun[g]),
            .clkCount (clkSel_r[g]),
            .mcTick   (mcTick),
            .wrLow    (timerWrLow[g]),
            .wrHigh   (timerWrHigh[g]),
            .wrData   (wrData),
            .count_r  (timerCount[g]),
            .reload_r (timerReload[g]),
            .ovf_r    (timerOvf[g])
         );
      end
   endgenerate

   // control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rateDbl_r  <= 1'b0;
         extraDbl_r <= 1'b0;
         t2Sel_r    <= 1'b0;
         tctrl_r    <= ubt_pkg::REG_RST;
         clkSel_r   <= 3'h0;
      end else if (wrStb) begin
         case (addr)
            ubt_pkg::ADDR_POWER:   rateDbl_r  <= wrData[ubt_pkg::POWER_DBL];
            ubt_pkg::ADDR_CONFIG:  extraDbl_r <= wrData[ubt_pkg::CONFIG_DBL];
            ubt_pkg::ADDR_SRCSEL:  t2Sel_r    <= wrData[ubt_pkg::SRC_T2];
            ubt_pkg::ADDR_TCTRL:   tctrl_r    <= wrData & ubt_pkg::TCTRL_MASK;
            ubt_pkg::ADDR_TCLKSEL: clkSel_r   <= wrData[2:0];
            default: ;
         endcase
      end
   end

   // serial control; a hardware set beats a software clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= ubt_pkg::REG_RST;
      end else begin
         if (wrCtrl) begin
            ctrl_r[7:3] <= wrData[7:3];
            ctrl_r[ubt_pkg::CTRL_TI] <= wrData[ubt_pkg::CTRL_TI] | tiSet;
            ctrl_r[ubt_pkg::CTRL_RI] <= wrData[ubt_pkg::CTRL_RI] | riSet;
         end else begin
            if (tiSet) ctrl_r[ubt_pkg::CTRL_TI] <= 1'b1;
            if (riSet) ctrl_r[ubt_pkg::CTRL_RI] <= 1'b1;
         end
         if (rb8Load) begin
            ctrl_r[ubt_pkg::CTRL_RB8] <= rb8Val;
         end else if (wrCtrl) begin
            ctrl_r[ubt_pkg::CTRL_RB8] <= wrData[ubt_pkg::CTRL_RB8];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_r <= 8'h00;
      end else if (!rdStb) begin
         rdData_r <= 8'h00;
      end else begin
         case (addr)
            ubt_pkg::ADDR_BUF:     rdData_r <= rxBuf_r;
            ubt_pkg::ADDR_CTRL:    rdData_r <= ctrl_r;
            ubt_pkg::ADDR_POWER:   rdData_r <= {rateDbl_r, 7'h00};
            ubt_pkg::ADDR_CONFIG:  rdData_r <= {7'h00, extraDbl_r};
            ubt_pkg::ADDR_SRCSEL:  rdData_r <= {7'h00, t2Sel_r};
            ubt_pkg::ADDR_TCTRL:   rdData_r <= tctrl_r;
            ubt_pkg::ADDR_TCLKSEL: rdData_r <= {5'h00, clkSel_r};
            ubt_pkg::ADDR_TLOW: begin
               case (sel)
                  ubt_pkg::SEL_T0: rdData_r <= timerCount[0];
                  ubt_pkg::SEL_T1: rdData_r <= timerCount[1];
                  ubt_pkg::SEL_T2: rdData_r <= timerCount[2];
                  default:         rdData_r <= 8'h00;
               endcase
            end
            ubt_pkg::ADDR_THIGH: begin
               case (sel)
                  ubt_pkg::SEL_T0: rdData_r <= timerReload[0];
                  ubt_pkg::SEL_T1: rdData_r <= timerReload[1];
                  ubt_pkg::SEL_T2: rdData_r <= timerReload[2];
                  default:         rdData_r <= 8'h00;
               endcase
            end
            default: rdData_r <= 8'h00;
         endcase
      end
   end
   assign rdData = rdData_r;

   // 16x sample tick
   logic [1:0] fixCnt_r;
   logic       ovfHalf_r;
   logic       srcOvf;
   logic       dblAny;
   logic       fixTick;
   logic       tick16;

   // reload FF or FE in clock-count mode overflows too fast to follow
   assign srcOvf = timerRun[0] ? timerOvf[0] :
                   (t2Sel_r ? genTimerTwoOvf : genTimerOneOvf);
   assign dblAny = rateDbl_r | extraDbl_r;

   always_comb begin
      case ({extraDbl_r, rateDbl_r})
         2'b00:   fixTick = (fixCnt_r == ubt_pkg::FIX64_LAST);
         2'b11:   fixTick = 1'b1;
         default: fixTick = fixCnt_r[0];
      endcase
   end

   assign tick16 = (mode == ubt_pkg::MODE_FIXED9) ? fixTick :
                   (srcOvf && (dblAny || ovfHalf_r));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fixCnt_r  <= 2'h0;
         ovfHalf_r <= 1'b0;
      end else begin
         fixCnt_r <= fixCnt_r + 2'h1;
         if (srcOvf) begin
            ovfHalf_r <= ~ovfHalf_r;
         end
      end
   end

   // receive pin through three flops; level changes once stages two and three agree
   logic [2:0] rxSync_r;
   logic       rxF_r;
   logic       rxPrev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxSync_r <= 3'b111;
         rxF_r    <= 1'b1;
         rxPrev_r <= 1'b1;
      end else begin
         rxSync_r <= {rxSync_r[1:0], rxdIn};
         if (rxSync_r[1] == rxSync_r[2]) begin
            rxF_r <= rxSync_r[2];
         end
         rxPrev_r <= rxF_r;
      end
   end

   // baud rollover every 16 ticks, free running so tx bits align to it
   logic [3:0] txDiv_r;
   logic       rollover;

   assign rollover = tick16 && (txDiv_r == ubt_pkg::TICK_LAST);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txDiv_r <= 4'h0;
      end else if (tick16) begin
         txDiv_r <= txDiv_r + 4'h1;
      end
   end

   // transmit and shift-mode engine
   ubt_pkg::ubt_tx_state_e txState_r;
   logic [10:0] txShift_r;
   logic [3:0]  txCnt_r;
   logic [5:0]  mcCnt_r;
   logic        m0Tx_r;
   logic [7:0]  m0Rx_r;
   logic        m0Window;
   logic        m0Start;
   logic [3:0]  frameLen;

   assign frameLen = (mode == ubt_pkg::MODE_ASYNC8) ? ubt_pkg::FRAME8 : ubt_pkg::FRAME9;
   assign m0Window = (mcCnt_r >= ubt_pkg::M0_LEAD_MC) && (mcCnt_r < ubt_pkg::M0_END_MC);
   assign m0Start  = (mode == ubt_pkg::MODE_SHIFT) && (wrBuf ||
                     (ctrl_r[ubt_pkg::CTRL_REN] && !ctrl_r[ubt_pkg::CTRL_RI]));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState_r <= ubt_pkg::TX_IDLE;
         txShift_r <= 11'h7FF;
         txCnt_r   <= 4'h0;
         mcCnt_r   <= 6'h00;
         m0Tx_r    <= 1'b0;
         m0Rx_r    <= 8'h00;
      end else begin
         case (txState_r)
            ubt_pkg::TX_IDLE: begin
               mcCnt_r <= 6'h00;
               txCnt_r <= 4'h0;
               if (m0Start) begin
                  txShift_r <= {3'h7, wrData};
                  m0Tx_r    <= wrBuf;
                  txState_r <= ubt_pkg::TX_SHIFT;
               end else if (wrBuf && mode != ubt_pkg::MODE_SHIFT) begin
                  txShift_r <= {1'b1, (mode == ubt_pkg::MODE_ASYNC8) |
                                ctrl_r[ubt_pkg::CTRL_TB8], wrData, 1'b0};
                  txState_r <= ubt_pkg::TX_ASYNC;
               end
            end
            ubt_pkg::TX_SHIFT: begin
               if (mcTick) begin
                  mcCnt_r <= mcCnt_r + 6'h01;
                  // sample on the rising shift clock, shift out at the bit's end
                  if (m0Window && mcCnt_r[1:0] == 2'h1 && !m0Tx_r) begin
                     m0Rx_r <= {rxF_r, m0Rx_r[7:1]};
                  end
                  if (m0Window && mcCnt_r[1:0] == 2'h3) begin
                     txShift_r <= {1'b1, txShift_r[10:1]};
                  end
                  if (mcCnt_r + 6'h01 == ubt_pkg::M0_END_MC) begin
                     txState_r <= ubt_pkg::TX_IDLE;
                  end
               end
            end
            ubt_pkg::TX_ASYNC: begin
               if (rollover) begin
                  txShift_r <= {1'b1, txShift_r[10:1]};
                  txCnt_r   <= txCnt_r + 4'h1;
                  if (txCnt_r + 4'h1 == frameLen) begin
                     txState_r <= ubt_pkg::TX_IDLE;
                  end
               end
            end
            default: txState_r <= ubt_pkg::TX_IDLE;
         endcase
      end
   end

   logic m0End;
   logic asyncEnd;
   assign m0End    = (txState_r == ubt_pkg::TX_SHIFT) && mcTick &&
                     (mcCnt_r + 6'h01 == ubt_pkg::M0_END_MC);
   assign asyncEnd = (txState_r == ubt_pkg::TX_ASYNC) && rollover &&
                     (txCnt_r + 4'h1 == frameLen);

   // async receiver
   ubt_pkg::ubt_rx_state_e rxState_r;
   logic [3:0] rxIdx_r;
   logic [7:0] rxShift_r;
   logic       rxStart;
   logic       bitStb;
   logic       bitVal;
   logic       rxLast;
   logic       rxAccept;

   assign rxStart = (rxState_r == ubt_pkg::RX_IDLE) && (mode != ubt_pkg::MODE_SHIFT) &&
                    ctrl_r[ubt_pkg::CTRL_REN] && rxPrev_r && !rxF_r;
   assign rxLast  = (rxState_r == ubt_pkg::RX_ASYNC) && bitStb &&
                    (rxIdx_r == ubt_pkg::RX_LAST_IDX);
   // last bit is the stop bit in 8-bit mode and the ninth bit in 9-bit modes
   assign rxAccept = rxLast && !ctrl_r[ubt_pkg::CTRL_RI] &&
                     (!ctrl_r[ubt_pkg::CTRL_MP] || bitVal);

   ubt_rx_sampler uSampler (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (rxStart),
      .tick16   (tick16),
      .rxd      (rxF_r),
      .bitStb_r (bitStb),
      .bitVal_r (bitVal)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxState_r <= ubt_pkg::RX_IDLE;
         rxIdx_r   <= 4'h0;
         rxShift_r <= 8'h00;
      end else begin
         case (rxState_r)
            ubt_pkg::RX_IDLE: begin
               rxIdx_r <= 4'h0;
               if (rxStart) begin
                  rxState_r <= ubt_pkg::RX_ASYNC;
               end
            end
            ubt_pkg::RX_ASYNC: begin
               if (bitStb) begin
                  rxIdx_r <= rxIdx_r + 4'h1;
                  // a start bit that votes high was noise
                  if (rxIdx_r == 4'h0 && bitVal) begin
                     rxState_r <= ubt_pkg::RX_IDLE;
                  end else if (rxLast) begin
                     rxState_r <= ubt_pkg::RX_IDLE;
                  end else if (rxIdx_r != 4'h0) begin
                     rxShift_r <= {bitVal, rxShift_r[7:1]};
                  end
               end
            end
            default: rxState_r <= ubt_pkg::RX_IDLE;
         endcase
      end
   end

   // holding buffer apart from the shifters
   assign riSet   = rxAccept || (m0End && !m0Tx_r);
   assign tiSet   = asyncEnd || (m0End && m0Tx_r);
   assign rb8Load = rxAccept;
   assign rb8Val  = bitVal;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxBuf_r <= 8'h00;
      end else if (rxAccept) begin
         rxBuf_r <= rxShift_r;
      end else if (m0End && !m0Tx_r) begin
         rxBuf_r <= m0Rx_r;
      end
   end

   // pins
   logic txd_r;
   logic rxdOut_r;
   logic rxdOe_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txd_r    <= 1'b1;
         rxdOut_r <= 1'b1;
         rxdOe_r  <= 1'b0;
      end else begin
         case (txState_r)
            ubt_pkg::TX_SHIFT: txd_r <= !(m0Window && !mcCnt_r[1]);
            ubt_pkg::TX_ASYNC: txd_r <= txShift_r[0];
            default:           txd_r <= 1'b1;
         endcase
         rxdOut_r <= txShift_r[0];
         rxdOe_r  <= (txState_r == ubt_pkg::TX_SHIFT) && m0Tx_r && m0Window;
      end
   end

   assign txd    = txd_r;
   assign rxdOut = rxdOut_r;
   assign rxdOe  = rxdOe_r;
endmodule

// *** dv/ubt_uart_with_baud_timers_props.sv ***
`timescale 1ns/1ps
module ubt_uart_with_baud_timers_props (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wrData,
   input wire logic       wrStb,
   input wire logic       rdStb,
   input wire logic [7:0] rdData,
   input wire logic       rxdOe,
   input wire logic       txd,
   input wire logic [2:0] timerOvf
);
   logic [1:0] modeSh_r;
   logic       runSh_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadows of software writes, so outputs can be tied to their cause
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modeSh_r <= 2'h0;
      end else if (wrStb && addr == ubt_pkg::ADDR_CTRL) begin
         modeSh_r <= wrData[7:6];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         runSh_r <= 1'b0;
      end else if (wrStb && addr == ubt_pkg::ADDR_TCTRL) begin
         runSh_r <= wrData[0];
      end
   end
   sequence m0Write;
      wrStb && addr == ubt_pkg::ADDR_BUF && modeSh_r == ubt_pkg::MODE_SHIFT
         && !rxdOe && txd;
   endsequence
   sequence m0Lead;
      !rxdOe [*8] ##[1:8] rxdOe;
   endsequence
   AST_M0_LEAD: assert property (m0Write |=> m0Lead)
      else $error("mode 0 lead wrong");
   AST_OE_MODE: assert property (rxdOe |-> modeSh_r == ubt_pkg::MODE_SHIFT)
      else $error("rxd driven outside mode 0");
   AST_RD_IDLE: assert property (!$past(rdStb) |-> rdData == 8'h00)
      else $error("read data without read");
   AST_UNMAPPED: assert property (rdStb && addr > ubt_pkg::ADDR_SRCSEL |=> rdData == 8'h00)
      else $error("unmapped read not zero");
   AST_TCLK_UPPER: assert property (rdStb && addr == ubt_pkg::ADDR_TCLKSEL
      |=> rdData[7:3] == 5'h00)
      else $error("clock select upper bits set");
   AST_TCTRL_RSV: assert property (rdStb && addr == ubt_pkg::ADDR_TCTRL
      |=> (rdData & ~ubt_pkg::TCTRL_MASK) == 8'h00)
      else $error("timer control reserved bits set");
   AST_OVF_RUN: assert property (timerOvf[0] |-> runSh_r || $past(runSh_r))
      else $error("overflow while stopped");
   AST_OVF_GAP: assert property (timerOvf[0] |=> !timerOvf[0] [*2])
      else $error("overflows too close");
endmodule
bind ubt_uart_with_baud_timers ubt_uart_with_baud_timers_props ubt_uart_with_baud_timers_props_inst (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
   .rdData(rdData), .rxdOe(rxdOe), .txd(txd), .timerOvf(timerOvf));

// *** dv/ubt_remote_serial.sv ***
`timescale 1ns/1ps
module ubt_remote_serial (
   input wire logic clk,
   input wire logic txd,
   output logic     line
);
   // line has a pull-up, so idle is high
   initial line = 1'b1;
   task automatic send(input logic [10:0] f, input int nb, input int bt);
      for (int i = 0; i < nb; i++) begin
         line <= f[i];
         repeat (bt) @(posedge clk);
      end
      line <= 1'b1;
   endtask
   // start bit may be short, so timing resyncs on the rise into bit 1: bit 1 must be 1
   task automatic recv(output logic [10:0] f, input int nb, input int bt);
      f = '1;
      while (txd !== 1'b0) @(negedge clk);
      f[0] = txd;
      while (txd !== 1'b1) @(negedge clk);
      repeat (bt / 2) @(negedge clk);
      for (int i = 1; i < nb; i++) begin
         f[i] = txd;
         repeat (bt) @(negedge clk);
      end
   endtask
endmodule

// *** dv/test_ubt_uart_with_baud_timers.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin numErrors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_ubt_uart_with_baud_timers;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wrData = 8'h00;
   logic        wrStb = 1'b0;
   logic        rdStb = 1'b0;
   logic [7:0]  rdData;
   logic        rxdOut;
   logic        rxdOe;
   logic        txd;
   logic [2:0]  timerOvf;
   logic        line;
   logic [1:0]  gtOvf = 2'b00;
   logic [7:0]  v;
   logic [7:0]  cap;
   logic [10:0] fr;
   int          numErrors = 0;
   int          samplesChecked = 0;
   int          n;
   wire logic   rxdPin = rxdOe ? rxdOut : line;
   always #2 clk = ~clk;
   // general timer one overflows every clock, timer two every other clock
   always @(posedge clk) gtOvf <= {~gtOvf[1], 1'b1};
   ubt_uart_with_baud_timers ubt_uart_with_baud_timers_inst (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .rxdIn(rxdPin), .rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd), .genTimerOneOvf(gtOvf[0]),
      .genTimerTwoOvf(gtOvf[1]), .timerOvf(timerOvf));
   ubt_remote_serial ubt_remote_serial_inst (.clk(clk), .txd(txd), .line(line));
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 v = rdData;
      `CHK(v & m, e)
   endtask
   task automatic ovfGap();
      while (timerOvf[0] !== 1'b1) @(negedge clk);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (timerOvf[0] !== 1'b1 && n < 99);
   endtask
   task automatic printVerdict();
      if (numErrors == 0 && samplesChecked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      numErrors++;
      printVerdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 9; a++) rdChk(a[3:0], 8'hFF, ubt_pkg::REG_RST);
      rdChk(4'hF, 8'hFF, 8'h00);
      wr(ubt_pkg::ADDR_TCLKSEL, 8'hFF);
      rdChk(ubt_pkg::ADDR_TCLKSEL, 8'hFF, 8'h07);
      // back to machine cycles before the timers are timed
      wr(ubt_pkg::ADDR_TCLKSEL, 8'h00);
      wr(ubt_pkg::ADDR_TCTRL, 8'hF4);
      rdChk(ubt_pkg::ADDR_TCTRL, 8'hFF, 8'hE0);
      for (int i = 0; i < 3; i++) begin
         wr(ubt_pkg::ADDR_TCTRL, 8'h20 << i);
         wr(ubt_pkg::ADDR_THIGH, 8'hA0 + i[7:0]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(ubt_pkg::ADDR_TCTRL, 8'h20 << i);
         rdChk(ubt_pkg::ADDR_THIGH, 8'hFF, 8'hA0 + i[7:0]);
      end
      wr(ubt_pkg::ADDR_TCTRL, 8'h00);
      rdChk(ubt_pkg::ADDR_THIGH, 8'hFF, 8'h00);
      // reload FD keeps clock counting legal
      wr(ubt_pkg::ADDR_TCTRL, 8'h21);
      wr(ubt_pkg::ADDR_THIGH, 8'hFD);
      ovfGap();
      `CHK(n, 9)
      `CHK(timerOvf[2:1], 2'b00)
      wr(ubt_pkg::ADDR_TCLKSEL, 8'h01);
      ovfGap();
      `CHK(n, 3)
      wr(ubt_pkg::ADDR_TCLKSEL, 8'h00);
      wr(ubt_pkg::ADDR_THIGH, 8'hFF);
      wr(ubt_pkg::ADDR_POWER, 8'h80);
      wr(ubt_pkg::ADDR_CTRL, 8'h50);
      fork
         ubt_remote_serial_inst.recv(fr, 10, 48);
         wr(ubt_pkg::ADDR_BUF, 8'hC3);
      join
      `CHK(fr, {2'b11, 8'hC3, 1'b0})
      rdChk(ubt_pkg::ADDR_CTRL, 8'h02, 8'h02);
      wr(ubt_pkg::ADDR_CTRL, 8'h50);
      ubt_remote_serial_inst.send({2'b11, 8'h5A, 1'b0}, 10, 48);
      rdChk(ubt_pkg::ADDR_CTRL, 8'h05, 8'h05);
      rdChk(ubt_pkg::ADDR_BUF, 8'hFF, 8'h5A);
      wr(ubt_pkg::ADDR_CTRL, 8'h70);
      ubt_remote_serial_inst.send({2'b00, 8'h81, 1'b0}, 10, 48);
      rdChk(ubt_pkg::ADDR_CTRL, 8'h01, 8'h00);
      rdChk(ubt_pkg::ADDR_BUF, 8'hFF, 8'h5A);
      wr(ubt_pkg::ADDR_CONFIG, 8'h01);
      wr(ubt_pkg::ADDR_CTRL, 8'hB8);
      fork
         ubt_remote_serial_inst.recv(fr, 11, 16);
         wr(ubt_pkg::ADDR_BUF, 8'hA5);
      join
      `CHK(fr, {2'b11, 8'hA5, 1'b0})
      ubt_remote_serial_inst.send({2'b10, 8'h3C, 1'b0}, 11, 16);
      rdChk(ubt_pkg::ADDR_CTRL, 8'h01, 8'h00);
      ubt_remote_serial_inst.send({2'b11, 8'h3C, 1'b0}, 11, 16);
      rdChk(ubt_pkg::ADDR_CTRL, 8'h05, 8'h05);
      rdChk(ubt_pkg::ADDR_BUF, 8'hFF, 8'h3C);
      wr(ubt_pkg::ADDR_CTRL, 8'h00);
      fork
         for (int i = 0; i < 8; i++) @(posedge txd) cap[i] = rxdOut;
         begin
            wr(ubt_pkg::ADDR_BUF, 8'h96);
            n = 0;
            v = 8'h00;
            while (v[1] !== 1'b1 && n < 400) begin
               rdChk(ubt_pkg::ADDR_CTRL, 8'hC0, 8'h00);
               n = n + 2;
            end
         end
      join
      `CHK(cap, 8'h96)
      `CHK(n >= 104 && n <= 114, 1'b1)
      // receive enable with done clear starts a mode 0 receive of the idle-high line
      wr(ubt_pkg::ADDR_CTRL, 8'h10);
      repeat (88) @(posedge clk);
      rdChk(ubt_pkg::ADDR_CTRL, 8'h01, 8'h00);
      repeat (20) @(posedge clk);
      rdChk(ubt_pkg::ADDR_CTRL, 8'h03, 8'h01);
      rdChk(ubt_pkg::ADDR_BUF, 8'hFF, 8'hFF);
      // dedicated timer stopped: timer two, not timer one, sets a 32-clock bit
      wr(ubt_pkg::ADDR_TCTRL, 8'h00);
      wr(ubt_pkg::ADDR_SRCSEL, 8'h01);
      wr(ubt_pkg::ADDR_CTRL, 8'h40);
      fork
         ubt_remote_serial_inst.recv(fr, 10, 32);
         wr(ubt_pkg::ADDR_BUF, 8'h5B);
      join
      `CHK(fr, {2'b11, 8'h5B, 1'b0})
      printVerdict();
   end
endmodule
